/* verilog/owh_master.sv */
// single-wire bus master: slot timing, crc check of write passes
`timescale 1ns/1ps
`default_nettype none
module owh_master
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic req,
   input wire owh_pkg::owh_op_t op,
   input wire logic [7:0] wdata,
   input wire logic crc_clear,
   input wire logic crc_load,
   input wire logic [15:0] crc_load_val,
   input wire logic crc_shift_tx,
   input wire logic crc_shift_rx,
   output logic busy,
   output logic done,
   output logic [7:0] rdata,
   output logic presence,
   output logic [15:0] crc_now,
   output logic crc_ok,
   output logic dq_o,
   output logic dq_oe,
   output logic vpp_en,
   input wire logic dq_i
);
   import owh_pkg::*;
   typedef enum logic [5:0]
   {
      ST_IDLE = 6'b000001,
      ST_RLOW = 6'b000010,
      ST_RHIGH = 6'b000100,
      ST_SLOT = 6'b001000,
      ST_REC = 6'b010000,
      ST_PROG = 6'b100000
   } owh_state_t;
   owh_state_t state_r;
   logic [CNT_W-1:0] cnt_r;
   logic [2:0] bit_r;
   logic [7:0] sh_r;
   logic rd_r;
   logic [1:0] pph_r;
   logic [15:0] rx_crc_r;
   logic [7:0] rdata_r;
   logic presence_r;
   logic done_r;
   logic crc_ok_r;
   logic crc_byte_r;
   owh_crc_if cif ();
   owh_crc16 u_crc
   (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .cif(cif)
   );
   // ---------------------------------------------------------------
   // crc engine control
   // ---------------------------------------------------------------
   logic shift_bit;
   assign shift_bit = (state_r == ST_SLOT) && (cnt_r == CNT_W'(SLOT_CYC - 1)) && crc_shift_tx;
   assign cif.clr = (state_r == ST_IDLE) && req && crc_clear;
   assign cif.load = (state_r == ST_IDLE) && req && crc_load && !crc_clear;
   assign cif.load_val = {crc_load_val[15:8] & TA_HIGH_MASK, crc_load_val[7:0]};
   assign cif.shift = shift_bit;
   assign cif.bit_in = sh_r[0];
   assign crc_now = cif.crc;
   property p_addr_high_zero;
      @(posedge clock) disable iff (!rst_n)
      cif.load |-> (cif.load_val[15:11] == 5'h00);
   endproperty
   a_addr_high_zero: assert property (p_addr_high_zero) else $error("address top bits reach the crc");
   // ---------------------------------------------------------------
   // slot sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ST_IDLE;
         cnt_r <= '0;
         bit_r <= 3'h0;
         sh_r <= 8'h00;
         rd_r <= 1'b0;
         pph_r <= 2'h0;
         done_r <= 1'b0;
      end
      else if (ce)
      begin
         done_r <= 1'b0;
         unique case (state_r)
            ST_IDLE:
            begin
               cnt_r <= '0;
               if (req)
               begin
                  bit_r <= 3'h0;
                  sh_r <= wdata;
                  rd_r <= (op == OWH_OP_READ);
                  pph_r <= 2'h0;
                  if (op == OWH_OP_RESET)
                     state_r <= ST_RLOW;
                  else if (op == OWH_OP_PROG)
                     state_r <= ST_PROG;
                  else
                     state_r <= ST_SLOT;
               end
            end
            ST_RLOW:
            begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == CNT_W'(RESET_LOW_CYC - 1))
               begin
                  cnt_r <= '0;
                  state_r <= ST_RHIGH;
               end
            end
            ST_RHIGH:
            begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == CNT_W'(RESET_HIGH_INTERVAL_CYC - 1))
               begin
                  state_r <= ST_IDLE;
                  done_r <= 1'b1;
               end
            end
            ST_SLOT:
            begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == CNT_W'(READ_VALID_WINDOW_SAMPLE_CYC - 1) && rd_r)
                  sh_r <= {dq_i, sh_r[7:1]};
               if (cnt_r == CNT_W'(SLOT_CYC - 1))
               begin
                  cnt_r <= '0;
                  if (!rd_r)
                     sh_r <= {1'b0, sh_r[7:1]};
                  state_r <= ST_REC;
               end
            end
            ST_REC:
            begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == CNT_W'(REC_CYC - 1))
               begin
                  cnt_r <= '0;
                  bit_r <= bit_r + 1'b1;
                  if (bit_r == 3'h7)
                  begin
                     state_r <= ST_IDLE;
                     done_r <= 1'b1;
                  end
                  else
                     state_r <= ST_SLOT;
               end
            end
            ST_PROG:
            begin
               cnt_r <= cnt_r + 1'b1;
               if ((pph_r == 2'h0 && cnt_r == CNT_W'(DELAY_PROG_CYC - 1)) ||
                   (pph_r == 2'h1 && cnt_r == CNT_W'(PROGRAM_PULSE_WIDTH_CYC - 1)))
               begin
                  cnt_r <= '0;
                  pph_r <= pph_r + 1'b1;
               end
               else if (pph_r == 2'h2 && cnt_r == CNT_W'(DELAY_VERIFY_CYC - 1))
               begin
                  state_r <= ST_IDLE;
                  done_r <= 1'b1;
               end
            end
         endcase
      end
   end
   // ---------------------------------------------------------------
   // presence detect and read byte
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         presence_r <= 1'b0;
      else if (ce && state_r == ST_RHIGH && cnt_r == CNT_W'(PRES_SAMPLE_CYC - 1))
         presence_r <= !dq_i;
   end
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         rdata_r <= 8'h00;
      else if (ce && state_r == ST_REC && bit_r == 3'h7 && cnt_r == CNT_W'(REC_CYC - 1))
         rdata_r <= sh_r;
   end
   // ---------------------------------------------------------------
   // received crc check: inverted, lsb byte first
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_crc_r <= 16'h0000;
         crc_byte_r <= 1'b0;
         crc_ok_r <= 1'b0;
      end
      else if (ce && done_r && rd_r && crc_shift_rx)
      begin
         crc_byte_r <= !crc_byte_r;
         if (!crc_byte_r)
            rx_crc_r[7:0] <= rdata_r;
         else
         begin
            rx_crc_r[15:8] <= rdata_r;
            crc_ok_r <= ({rdata_r, rx_crc_r[7:0]} == ~cif.crc);
         end
      end
   end
   // ---------------------------------------------------------------
   // pin drive
   // ---------------------------------------------------------------
   always_comb
   begin
      dq_o = 1'b0;
      dq_oe = 1'b0;
      vpp_en = 1'b0;
      unique case (state_r)
         ST_RLOW:
            dq_oe = 1'b1;
         ST_SLOT:
            if (rd_r || sh_r[0])
               dq_oe = (cnt_r < CNT_W'(LOW1_CYC));
            else
               dq_oe = 1'b1;
         ST_PROG:
            vpp_en = (pph_r == 2'h1);
         default:
            dq_oe = 1'b0;
      endcase
   end
   // 25 cycles per us: short low at least 1 us, released by 15 us
   property p_one_low;
      @(posedge clock) disable iff (!rst_n)
      (state_r == ST_SLOT) && (rd_r || sh_r[0]) && $rose(dq_oe) |-> ##24 dq_oe ##[1:350] !dq_oe;
   endproperty
   a_one_low: assert property (p_one_low) else $error("short low time out of range");
   property p_vpp_oe;
      @(posedge clock) disable iff (!rst_n)
      !(vpp_en && dq_oe);
   endproperty
   a_vpp_oe: assert property (p_vpp_oe) else $error("program voltage while line pulled low");
   property p_prog_delay;
      @(posedge clock) disable iff (!rst_n)
      $rose(vpp_en) |-> $past(state_r == ST_PROG, 125);
   endproperty
   a_prog_delay: assert property (p_prog_delay) else $error("program pulse started too early");
   property p_verify_delay;
      @(posedge clock) disable iff (!rst_n)
      $fell(vpp_en) |-> ##124 (busy && !dq_oe);
   endproperty
   a_verify_delay: assert property (p_verify_delay) else $error("line used too soon after pulse");
   assign busy = (state_r != ST_IDLE);
   assign done = done_r;
   assign rdata = rdata_r;
   assign presence = presence_r;
   assign crc_ok = crc_ok_r;
endmodule
`default_nettype wire

/* verilog/owh_pkg.sv */
// package: constants and types for the single-wire bus master
package owh_pkg;
   localparam int unsigned CLK_MHZ = 25;
   // times in microseconds
   localparam int unsigned RESET_LOW_US = 480;
   localparam int unsigned RESET_HIGH_US = 480;
   localparam int unsigned SLOT_US = 70;
   localparam int unsigned REC_US = 2;
   localparam int unsigned LOW1_US = 6;
   localparam int unsigned SAMPLE_US = 13;
   localparam int unsigned PRES_SAMPLE_US = 70;
   localparam int unsigned DELAY_PROG_US = 5;
   localparam int unsigned PROGRAM_PULSE_WIDTH_US = 480;
   localparam int unsigned DELAY_VERIFY_US = 5;
   // cycle counts, minima rounded up
   localparam int unsigned RESET_LOW_CYC = RESET_LOW_US * CLK_MHZ;
   localparam int unsigned RESET_HIGH_INTERVAL_CYC = RESET_HIGH_US * CLK_MHZ;
   localparam int unsigned SLOT_CYC = SLOT_US * CLK_MHZ;
   localparam int unsigned REC_CYC = REC_US * CLK_MHZ;
   localparam int unsigned LOW1_CYC = LOW1_US * CLK_MHZ;
   localparam int unsigned READ_VALID_WINDOW_SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
   localparam int unsigned PRES_SAMPLE_CYC = PRES_SAMPLE_US * CLK_MHZ;
   localparam int unsigned DELAY_PROG_CYC = DELAY_PROG_US * CLK_MHZ;
   localparam int unsigned PROGRAM_PULSE_WIDTH_CYC = PROGRAM_PULSE_WIDTH_US * CLK_MHZ;
   localparam int unsigned DELAY_VERIFY_CYC = DELAY_VERIFY_US * CLK_MHZ;
   localparam int unsigned CNT_W = 16;
   // crc-16 x^16 + x^15 + x^2 + 1, reflected
   localparam logic [15:0] CRC_POLY_REFL = 16'ha001;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   localparam logic [7:0] TA_HIGH_MASK = 8'h07;
   typedef enum logic [2:0]
   {
      OWH_OP_RESET = 3'h0,
      OWH_OP_WRITE = 3'h1,
      OWH_OP_READ = 3'h2,
      OWH_OP_PROG = 3'h3
   } owh_op_t;
endpackage

/* verilog/owh_crc_if.sv */
// interface: crc engine command and state
`timescale 1ns/1ps
`default_nettype none
interface owh_crc_if;
   logic clr;
   logic load;
   logic [15:0] load_val;
   logic shift;
   logic bit_in;
   logic [15:0] crc;
   modport ctrl (output clr, output load, output load_val, output shift, output bit_in, input crc);
   modport eng (input clr, input load, input load_val, input shift, input bit_in, output crc);
endinterface
`default_nettype wire

/* verilog/owh_crc16.sv */
// crc-16 engine, one bit per shift
`timescale 1ns/1ps
`default_nettype none
module owh_crc16
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   owh_crc_if.eng cif
);
   import owh_pkg::*;
   logic [15:0] crc_r;
   assign cif.crc = crc_r;
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         crc_r <= 16'h0000;
      else if (ce)
      begin
         if (cif.clr)
            crc_r <= CRC_INIT;
         else if (cif.load)
            crc_r <= cif.load_val;
         else if (cif.shift)
            crc_r <= (crc_r >> 1) ^ (((crc_r[0] ^ cif.bit_in)) ? CRC_POLY_REFL : 16'h0000);
      end
   end
   property p_crc_clear;
      @(posedge clock) disable iff (!rst_n)
      ce && cif.clr |=> (cif.crc == CRC_INIT);
   endproperty
   a_crc_clear: assert property (p_crc_clear) else $error("crc engine not cleared");
   property p_crc_load;
      @(posedge clock) disable iff (!rst_n)
      ce && cif.load && !cif.clr |=> (cif.crc == $past(cif.load_val));
   endproperty
   a_crc_load: assert property (p_crc_load) else $error("crc engine did not load the address");
endmodule
`default_nettype wire

/* verification/owh_dev_model.sv */
// behavioural single-wire device: presence, bit sampling, crc return
`timescale 1ns/1ps
`default_nettype none
module owh_dev_model
(
   input wire logic line,
   input wire logic vpp_en,
   input wire logic [15:0] addr,
   output logic pull_low,
   output int viol
);
   logic [15:0] crc, txq;
   int tx_n, nbits;
   logic rd, was_rst;
   realtime t0, lo, t1 = -1.0e9, tp = -1.0e9, tv = 0.0;
   initial
   begin
      pull_low = 1'b0;
      viol = 0;
      tx_n = 0;
      nbits = 0;
      was_rst = 1'b0;
      #100;
      forever
      begin
         @(negedge line);
         t0 = $realtime;
         if (t0 - t1 < 1000.0 || t0 - tp < 61000.0) viol++;
         if (was_rst && t0 - t1 < 480000.0) viol++;
         tp = t0;
         was_rst = 1'b0;
         rd = (tx_n != 0);
         if (rd)
         begin
            #500 pull_low = ~txq[0];
            #29500 pull_low = 1'b0;
            txq = txq >> 1;
            tx_n--;
         end
         wait (line === 1'b1);
         t1 = $realtime;
         lo = t1 - t0;
         if (lo >= 480000.0)
         begin
            was_rst = 1'b1;
            nbits = 0;
            crc = {5'h00, addr[10:0]};
            #30000 pull_low = 1'b1;
            #100000 pull_low = 1'b0;
         end
         else if (!rd)
         begin
            if (!((lo >= 1000.0 && lo <= 15000.0) || (lo >= 60000.0 && lo <= 120000.0))) viol++;
            crc = (crc >> 1) ^ (((lo < 15000.0) ^ crc[0]) ? 16'ha001 : 16'h0000);
            nbits++;
            if (nbits == 8)
            begin
               txq = ~crc;
               tx_n = 16;
            end
         end
      end
   end
   always @(posedge vpp_en)
   begin
      tv = $realtime;
      if (tv - t1 < 5000.0) viol++;
   end
   always @(negedge vpp_en)
      if (tv > 0.0 && $realtime - tv < 480000.0) viol++;
endmodule
`default_nettype wire

/* verification/owh_tb.sv */
// testbench: single-wire master against a behavioural device
`timescale 1ns/1ps
`default_nettype none
module tb;
   import owh_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic req = 1'b0;
   owh_op_t op = OWH_OP_RESET;
   logic ld = 1'b0;
   logic stx = 1'b0;
   logic srx = 1'b0;
   logic ce = 1'b1;
   logic clr = 1'b0;
   logic [7:0] wd = 8'h3c;
   logic busy, done, presence, crc_ok, dq_o, dq_oe, vpp_en, pull_low;
   logic [7:0] rdata;
   logic [15:0] crc_now;
   wire logic line;
   int viol;
   int mismatches = 0;
   int num_checks = 0;
   // open-drain line with pull-up
   assign line = (dq_oe ? dq_o : 1'b1) & ~pull_low;
   always #20 clock = ~clock;
   owh_master dut_u (.clock(clock), .rst_n(rst_n), .ce(ce), .req(req), .op(op), .wdata(wd),
      .crc_clear(clr), .crc_load(ld), .crc_load_val(16'hf8a5), .crc_shift_tx(stx), .crc_shift_rx(srx),
      .busy(busy), .done(done), .rdata(rdata), .presence(presence), .crc_now(crc_now), .crc_ok(crc_ok),
      .dq_o(dq_o), .dq_oe(dq_oe), .vpp_en(vpp_en), .dq_i(line));
   owh_dev_model dev_u (.line(line), .vpp_en(vpp_en), .addr(16'hf8a5), .pull_low(pull_low), .viol(viol));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic run_op(input owh_op_t o, input logic l, input logic t, input logic r);
      int n;
      @(negedge clock);
      op = o;
      ld = l;
      stx = t;
      srx = r;
      req = 1'b1;
      @(negedge clock);
      req = 1'b0;
      ld = 1'b0;
      check(16'(busy), 16'h0001);
      for (n = 0; n < 30000 && done !== 1'b1; n++) @(negedge clock);
      if (done !== 1'b1)
      begin
         mismatches++;
         summarize();
      end
      // shift flags stand through the cycle after done
      @(negedge clock);
      stx = 1'b0;
      srx = 1'b0;
   endtask
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 16'ha001 : 16'h0000);
      return c;
   endfunction
   task automatic sc_reset();
      run_op(OWH_OP_RESET, 1'b0, 1'b0, 1'b0);
      check(16'(presence), 16'h0001);
      check(16'(dq_o), 16'h0000);
      check(16'(viol), 16'h0000);
   endtask
   task automatic sc_write_crc();
      logic [15:0] exp;
      exp = crc_byte(16'hf8a5 & 16'h07ff, 8'h3c);
      run_op(OWH_OP_WRITE, 1'b1, 1'b1, 1'b0);
      check(crc_now, exp);
      run_op(OWH_OP_READ, 1'b0, 1'b0, 1'b1);
      check(16'(rdata), {8'h00, ~exp[7:0]});
      run_op(OWH_OP_READ, 1'b0, 1'b0, 1'b1);
      check(16'(rdata), {8'h00, ~exp[15:8]});
      check(16'(crc_ok), 16'h0001);
      check(16'(viol), 16'h0000);
   endtask
   task automatic sc_prog();
      run_op(OWH_OP_PROG, 1'b0, 1'b0, 1'b0);
      check(16'(vpp_en), 16'h0000);
      check(16'(viol), 16'h0000);
   endtask
   task automatic sc_freeze();
      @(negedge clock);
      ce = 1'b0;
      op = OWH_OP_RESET;
      req = 1'b1;
      repeat (2) @(negedge clock);
      check(16'(busy), 16'h0000);
      req = 1'b0;
      ce = 1'b1;
      @(negedge clock);
      check(16'(busy), 16'h0000);
   endtask
   task automatic sc_first_pass();
      logic [15:0] exp;
      wd = 8'h5a;
      exp = crc_byte(16'h0000, 8'h5a);
      clr = 1'b1;
      run_op(OWH_OP_WRITE, 1'b0, 1'b1, 1'b0);
      clr = 1'b0;
      check(crc_now, exp);
      check(16'(viol), 16'h0000);
   endtask
   initial
   begin
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      sc_reset();
      sc_write_crc();
      sc_prog();
      sc_freeze();
      sc_first_pass();
      summarize();
   end
endmodule
`default_nettype wire
